// ===== design/buf_if.sv
`timescale 1ns/1ps
interface buf_if #(parameter int WIDTH = 8);
    logic [WIDTH-1:0] in_data;
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] out_data;
    logic             out_valid;
    logic             out_ready;

    modport store (input in_data, input in_valid, output in_ready,
                   output out_data, output out_valid, input out_ready);
    modport user  (output in_data, output in_valid, input in_ready,
                   input out_data, input out_valid, output out_ready);
endinterface : buf_if

// ===== design/spi_master.sv
// The address-and-strobe port was decided locally.
`timescale 1ns/1ps
module spi_master
    import spi_pkg::*;
(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // Register port
    input  wire logic [11:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic      [7:0]  rdata,
    // Serial expansion port
    output logic             sclk,
    output logic             mosi,
    input  wire logic        miso,
    output logic      [6:0]  select_n,
    // Peripheral interrupt and host lines IRQ3, IRQ4, IRQ5, IRQ10
    input  wire logic        periph_irq_in_n,
    output logic      [3:0]  host_irq,
    // Start refused because the command buffer was full
    output logic             start_dropped
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic miso_meta;
    logic miso_sync;
    logic irq_meta_n;
    logic irq_sync_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            miso_meta  <= 1'b0;
            miso_sync  <= 1'b0;
            irq_meta_n <= 1'b1;
            irq_sync_n <= 1'b1;
        end else begin
            miso_meta  <= miso;
            miso_sync  <= miso_meta;
            irq_meta_n <= periph_irq_in_n;
            irq_sync_n <= irq_meta_n;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_one;
    logic [7:0]  ctrl_two;
    logic [31:0] data;
    logic [7:0]  next_ctrl_one;
    logic [7:0]  next_ctrl_two;
    logic [31:0] next_data;
    logic [7:0]  next_rdata;
    logic        next_dropped;

    logic [1:0]  irq_choice;
    logic [1:0]  rate;
    logic        irq_enable;
    logic        low_first;
    logic        irq_status;
    logic        busy;
    logic [1:0]  len_field;
    logic        manual;
    logic [2:0]  sel_field;
    logic        start_write;
    logic        frame_done;
    logic [31:0] rx_word;
    logic [31:0] rx_mask;

    assign irq_choice = ctrl_two[CHOICE_LSB +: 2];
    assign rate       = ctrl_two[RATE_LSB +: 2];
    assign irq_enable = ctrl_two[IRQ_EN_BIT];
    assign low_first  = ctrl_two[LOW_FIRST_BIT];
    assign irq_status = ~irq_sync_n;
    assign len_field  = ctrl_one[LEN_LSB +: 2];
    assign manual     = ctrl_one[MANUAL_BIT];
    assign sel_field  = ctrl_one[SEL_LSB +: 3];
    assign start_write = wr && (addr == DATA3_OFS);

    // Command buffer between the start write and the shift engine
    buf_if #(.WIDTH(CMD_W)) cmd_q ();
    cmd_t cmd_head;

    assign cmd_q.in_valid = start_write;
    assign cmd_q.in_data  = {{wdata, data[23:0]}, len_field, low_first};
    assign cmd_head       = cmd_q.out_data;

    two_entry_buffer #(.WIDTH(CMD_W), .DEPTH(2)) u_cmd_buf (
        .clk     (clk),
        .reset_n (reset_n),
        .bus     (cmd_q)
    );

    // Register writes, received-data return and read mux
    always_comb begin
        next_ctrl_one = ctrl_one;
        next_ctrl_two = ctrl_two;
        next_data     = data;
        next_rdata    = UNMAPPED_READ;
        next_dropped  = start_write && !cmd_q.in_ready;
        // Received frame lands in its own bytes only
        if (frame_done) begin
            next_data = (data & ~rx_mask) | (rx_word & rx_mask);
        end
        if (wr) begin
            case (addr)
                CTRL_ONE_OFS: next_ctrl_one = wdata;
                // Status and busy bits are not writable
                CTRL_TWO_OFS: next_ctrl_two = {wdata[7:2], 2'b00};
                DATA0_OFS:    next_data[7:0]   = wdata;
                DATA1_OFS:    next_data[15:8]  = wdata;
                DATA2_OFS:    next_data[23:16] = wdata;
                DATA3_OFS:    next_data[31:24] = wdata;
                default:      next_data = next_data;
            endcase
        end
        if (rd) begin
            case (addr)
                CTRL_ONE_OFS: next_rdata = ctrl_one;
                CTRL_TWO_OFS: next_rdata = {ctrl_two[7:2], irq_status, busy};
                DATA0_OFS:    next_rdata = data[7:0];
                DATA1_OFS:    next_rdata = data[15:8];
                DATA2_OFS:    next_rdata = data[23:16];
                DATA3_OFS:    next_rdata = data[31:24];
                default:      next_rdata = UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ctrl_one      <= CTRL_ONE_RESET;
            ctrl_two      <= CTRL_TWO_RESET;
            data          <= DATA_RESET;
            rdata         <= UNMAPPED_READ;
            start_dropped <= 1'b0;
        end else begin
            ctrl_one      <= next_ctrl_one;
            ctrl_two      <= next_ctrl_two;
            data          <= next_data;
            rdata         <= next_rdata;
            start_dropped <= next_dropped;
        end
    end

    // ------------------------------------------------------------
    // Shift engine
    // ------------------------------------------------------------
    state_t      state;
    state_t      next_state;
    logic [31:0] shreg;
    logic [31:0] next_shreg;
    logic [6:0]  tick;
    logic [6:0]  next_tick;
    logic [5:0]  bits_left;
    logic [5:0]  next_bits_left;
    logic [1:0]  cur_len;
    logic [1:0]  next_cur_len;
    logic        cur_low;
    logic        next_cur_low;
    logic        next_sclk;
    logic        next_mosi;
    logic        half_done;

    assign half_done          = (tick == 7'h01);
    assign cmd_q.out_ready    = (state == ST_IDLE);
    assign busy               = (state != ST_IDLE) || cmd_q.out_valid;
    assign frame_done         = (state == ST_DONE);
    assign rx_word            = shreg;
    assign rx_mask            = frame_mask(cur_len);

    // Bit that goes out first or next for the chosen order
    function automatic logic out_bit(input logic [31:0] w, input logic [1:0] len,
                                     input logic lo);
        out_bit = lo ? w[frame_low(len)] : w[31];
    endfunction : out_bit

    // Next values of the engine
    always_comb begin
        next_state     = state;
        next_shreg     = shreg;
        next_tick      = tick;
        next_bits_left = bits_left;
        next_cur_len   = cur_len;
        next_cur_low   = cur_low;
        next_sclk      = sclk;
        next_mosi      = mosi;
        case (state)
            ST_IDLE: begin
                next_sclk = 1'b0;
                if (cmd_q.out_valid) begin
                    next_shreg     = cmd_head.word;
                    next_cur_len   = cmd_head.len;
                    next_cur_low   = cmd_head.low_first;
                    next_bits_left = 6'({cmd_head.len, 3'h0} + 5'h08);
                    next_tick      = half_count(rate);
                    next_mosi      = out_bit(cmd_head.word, cmd_head.len,
                                             cmd_head.low_first);
                    next_state     = ST_SETUP;
                end
            end
            // Data settles for a half period before the first rising edge
            ST_SETUP: begin
                next_tick = 7'(tick - 7'h01);
                if (half_done) begin
                    next_sclk  = 1'b1;
                    next_tick  = half_count(rate);
                    next_state = ST_HIGH;
                end
            end
            ST_HIGH: begin
                next_tick   = 7'(tick - 7'h01);
                if (half_done) begin
                    next_sclk      = 1'b0;
                    next_tick      = half_count(rate);
                    next_bits_left = 6'(bits_left - 6'h01);
                    if (cur_low) begin
                        next_shreg     = shreg >> 1;
                        next_shreg[31] = miso_sync;
                    end else begin
                        next_shreg = shreg << 1;
                        next_shreg[frame_low(cur_len)] = miso_sync;
                    end
                    next_mosi  = out_bit(next_shreg, cur_len, cur_low);
                    next_state = (bits_left == 6'h01) ? ST_DONE : ST_LOW;
                end
            end
            ST_LOW: begin
                next_tick = 7'(tick - 7'h01);
                if (half_done) begin
                    next_sclk  = 1'b1;
                    next_tick  = half_count(rate);
                    next_state = ST_HIGH;
                end
            end
            // Result written back this cycle; busy and select drop after
            ST_DONE: begin
                next_state = ST_IDLE;
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state     <= ST_IDLE;
            shreg     <= DATA_RESET;
            tick      <= 7'h00;
            bits_left <= 6'h00;
            cur_len   <= 2'h0;
            cur_low   <= 1'b0;
            sclk      <= 1'b0;
            mosi      <= 1'b0;
        end else begin
            state     <= next_state;
            shreg     <= next_shreg;
            tick      <= next_tick;
            bits_left <= next_bits_left;
            cur_len   <= next_cur_len;
            cur_low   <= next_cur_low;
            sclk      <= next_sclk;
            mosi      <= next_mosi;
        end
    end

    // ------------------------------------------------------------
    // Slave selects and host interrupt lines
    // ------------------------------------------------------------
    logic [6:0] next_select_n;
    logic [3:0] next_host_irq;
    logic       frame_active;

    assign frame_active = (state == ST_SETUP) || (state == ST_HIGH) || (state == ST_LOW);

    // One active-low line per target; code 000 selects nothing
    function automatic logic [6:0] select_decode(input logic [2:0] code);
        select_decode = 7'h7F;
        if (code != 3'h0) begin
            select_decode[code - 3'h1] = 1'b0;
        end
    endfunction : select_decode

    always_comb begin
        next_select_n = 7'h7F;
        if (manual) begin
            next_select_n = select_decode(sel_field);
        end else if (frame_active) begin
            next_select_n = select_decode(sel_field);
        end
        next_host_irq = 4'h0;
        if (irq_enable && irq_status) begin
            next_host_irq[irq_choice] = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            select_n <= 7'h7F;
            host_irq <= 4'h0;
        end else begin
            select_n <= next_select_n;
            host_irq <= next_host_irq;
        end
    end

endmodule : spi_master

// ===== design/spi_pkg.sv
package spi_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_ONE_OFS = 12'hCA8;
    localparam logic [11:0] CTRL_TWO_OFS = 12'hCA9;
    localparam logic [11:0] DATA0_OFS    = 12'hCAA;
    localparam logic [11:0] DATA1_OFS    = 12'hCAB;
    localparam logic [11:0] DATA2_OFS    = 12'hCAC;
    localparam logic [11:0] DATA3_OFS    = 12'hCAD;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CHOICE_LSB    = 6;
    localparam int RATE_LSB      = 4;
    localparam int IRQ_EN_BIT    = 3;
    localparam int LOW_FIRST_BIT = 2;
    localparam int STATUS_BIT    = 1;
    localparam int BUSY_BIT      = 0;
    localparam int LEN_LSB       = 4;
    localparam int MANUAL_BIT    = 3;
    localparam int SEL_LSB       = 0;
    localparam logic [7:0]  CTRL_ONE_RESET = 8'h00;
    localparam logic [7:0]  CTRL_TWO_RESET = 8'h00;
    localparam logic [31:0] DATA_RESET     = 32'h0000_0000;
    localparam logic [7:0]  UNMAPPED_READ  = 8'h00;

    // ------------------------------------------------------------
    // Timing: rates in kHz, half periods in system clocks
    // ------------------------------------------------------------
    localparam int CLK_KHZ   = 100000;
    localparam int RATE0_KHZ = 1042;
    localparam int RATE1_KHZ = 2083;
    localparam int RATE2_KHZ = 4167;
    localparam int RATE3_KHZ = 8333;
    localparam logic [6:0] HALF0 = 7'((CLK_KHZ + RATE0_KHZ) / (2 * RATE0_KHZ));
    localparam logic [6:0] HALF1 = 7'((CLK_KHZ + RATE1_KHZ) / (2 * RATE1_KHZ));
    localparam logic [6:0] HALF2 = 7'((CLK_KHZ + RATE2_KHZ) / (2 * RATE2_KHZ));
    localparam logic [6:0] HALF3 = 7'((CLK_KHZ + RATE3_KHZ) / (2 * RATE3_KHZ));

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_HIGH, ST_LOW, ST_DONE} state_t;

    typedef struct packed {
        logic [31:0] word;
        logic [1:0]  len;
        logic        low_first;
    } cmd_t;

    localparam int CMD_W = $bits(cmd_t);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [6:0] half_count(input logic [1:0] rate);
        case (rate)
            2'h0:    half_count = HALF0;
            2'h1:    half_count = HALF1;
            2'h2:    half_count = HALF2;
            default: half_count = HALF3;
        endcase
    endfunction : half_count

    // Bits of the 32-bit word that the frame occupies (top bytes)
    function automatic logic [31:0] frame_mask(input logic [1:0] len);
        case (len)
            2'h0:    frame_mask = 32'hFF00_0000;
            2'h1:    frame_mask = 32'hFFFF_0000;
            2'h2:    frame_mask = 32'hFFFF_FF00;
            default: frame_mask = 32'hFFFF_FFFF;
        endcase
    endfunction : frame_mask

    // Index of the frame's lowest bit
    function automatic logic [4:0] frame_low(input logic [1:0] len);
        frame_low = 5'(5'h18 - {len, 3'h0});
    endfunction : frame_low

endpackage : spi_pkg

// ===== design/two_entry_buffer.sv
`timescale 1ns/1ps
module two_entry_buffer #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Both sides
    buf_if.store     bus
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (DEPTH != 2 || WIDTH < 1) begin : g_bad
        $error("two_entry_buffer needs DEPTH of 2 and WIDTH of at least 1");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic             wr_ptr;
    logic             rd_ptr;
    logic [1:0]       count;
    logic             next_wr_ptr;
    logic             next_rd_ptr;
    logic [1:0]       next_count;
    logic             push;
    logic             pop;

    // Handshakes on both sides; full and empty come from the count
    assign bus.in_ready  = (count != 2'h2);
    assign bus.out_valid = (count != 2'h0);
    assign bus.out_data  = mem[rd_ptr];
    assign push          = bus.in_valid && bus.in_ready;
    assign pop           = bus.out_valid && bus.out_ready;

    // Pointer and count next values
    always_comb begin
        next_wr_ptr = push ? ~wr_ptr : wr_ptr;
        next_rd_ptr = pop ? ~rd_ptr : rd_ptr;
        next_count  = 2'(count + {1'b0, push} - {1'b0, pop});
    end

    // Pointer and count registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_ptr <= 1'b0;
            rd_ptr <= 1'b0;
            count  <= 2'h0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage, written only on a push
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= bus.in_data;
        end
    end

endmodule : two_entry_buffer

// ===== verification/spi_master_monitor.sv
`timescale 1ns/1ps
module spi_master_monitor
    import spi_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        reset_n,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [7:0]  wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [7:0]  rdata,
    // Serial port and interrupts
    input wire logic        sclk,
    input wire logic [6:0]  select_n,
    input wire logic        periph_irq_in_n,
    input wire logic [3:0]  host_irq,
    input wire logic        start_dropped
);
    logic [7:0] c1;
    logic [7:0] c2;
    logic [6:0] hi_cnt;
    logic [5:0] rises;
    logic [2:0] hold;
    logic       rd_two;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Shadow control registers, high time, bit count and input age
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            c1     <= 8'h00;
            c2     <= 8'h00;
            hi_cnt <= 7'h00;
            rises  <= 6'h00;
            hold   <= 3'h0;
            rd_two <= 1'b0;
        end else begin
            if (wr && addr == CTRL_ONE_OFS) c1 <= wdata;
            if (wr && addr == CTRL_TWO_OFS) c2 <= wdata;
            hi_cnt <= sclk ? hi_cnt + 7'h01 : 7'h00;
            rises  <= (select_n == 7'h7F) ? 6'h00 : rises + 6'($rose(sclk));
            hold   <= $changed(periph_irq_in_n) ? 3'h0 : (hold == 3'h7 ? hold : hold + 3'h1);
            rd_two <= rd && addr == CTRL_TWO_OFS;
        end
    end

    irq_route_a: assert property (host_irq != 4'h0 |-> $past(c2[3]) &&
        host_irq == 4'h1 << $past(c2[7:6])) else $error("host line wrong or not enabled");
    irq_assert_a: assert property ((!periph_irq_in_n && c2[3]) [*5] |-> host_irq != 4'h0)
        else $error("host line not raised");
    irq_clear_a: assert property (periph_irq_in_n [*5] |-> host_irq == 4'h0)
        else $error("host line held after release");
    status_read_a: assert property (rd_two && hold == 3'h7 |-> rdata[1] == !periph_irq_in_n)
        else $error("status bit wrong");
    ctrl_read_a: assert property (rd_two |-> rdata[7:2] == c2[7:2])
        else $error("control readback wrong");
    busy_read_a: assert property (rd_two && $past(sclk) |-> rdata[0])
        else $error("busy low while shifting");
    sclk_select_a: assert property (sclk |-> select_n != 7'h7F)
        else $error("shift clock with no select");
    one_select_a: assert property ($onehot0(~select_n))
        else $error("several selects active");
    half_period_a: assert property ($fell(sclk) |-> hi_cnt == (c2[5:4] == 2'h0 ? HALF0 :
        c2[5:4] == 2'h1 ? HALF1 : c2[5:4] == 2'h2 ? HALF2 : HALF3)) else $error("half period wrong");
    frame_bits_a: assert property ($rose(select_n == 7'h7F) && !c1[3] |->
        rises == 6'({c1[5:4], 3'h0} + 6'h08)) else $error("bit count wrong");

    cover property ($fell(sclk));
    cover property (start_dropped);
    cover property (host_irq[3]);
endmodule : spi_master_monitor

bind spi_master spi_master_monitor mon (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata,
    .sclk, .select_n, .periph_irq_in_n, .host_irq, .start_dropped);

// ===== verification/spi_master_with_irq_routing_bench.sv
`timescale 1ns/1ps
module spi_master_with_irq_routing_bench
    import spi_pkg::*;
;
    logic        clk = 0, reset_n = 0, wr = 0, rd = 0, periph_irq_in_n = 1;
    logic [11:0] addr = 12'h000;
    logic [7:0]  wdata = 8'h00, rdata, d;
    logic        sclk, mosi, miso, start_dropped;
    logic [6:0]  select_n;
    logic [3:0]  host_irq;
    logic [31:0] reply = 32'h0, got, word, exp_w;
    int          nbits, n_fail = 0, checks = 0, drops;

    always #5 clk = ~clk;

    spi_master uut (.clk, .reset_n, .addr, .wdata, .wr, .rd, .rdata, .sclk, .mosi, .miso,
        .select_n, .periph_irq_in_n, .host_irq, .start_dropped);
    spi_periph_model peer (.sclk, .mosi, .select_n, .miso, .reply, .got, .nbits);

    task check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task finish_test;
        $display("comparisons %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task wr_reg(input logic [11:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task rd_reg(input logic [11:0] a);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task wait_idle;
        int i;
        for (i = 0; i < 4000; i++) begin
            rd_reg(CTRL_TWO_OFS);
            if (d[0] === 1'b0) break;
        end
        if (i == 4000) begin
            n_fail++;
            finish_test();
        end
    endtask : wait_idle

    function automatic logic [31:0] rev(input logic [31:0] x, input int n);
        rev = 32'h0;
        for (int k = 0; k < n; k++) rev[k] = x[n-1-k];
    endfunction : rev

    // One frame in automatic select mode, then data and line checks
    task xfer(input logic [1:0] len, input logic lsb, input logic [1:0] rate, input logic [2:0] sel);
        int n;
        logic [31:0] f;
        logic [31:0] r;
        n = 8 * (int'(len) + 1);
        word = $urandom;
        reply = $urandom;
        wr_reg(CTRL_ONE_OFS, {2'h0, len, 1'b0, sel});
        wr_reg(CTRL_TWO_OFS, {2'h0, rate, 1'b0, lsb, 2'h0});
        for (int b = 0; b < 4; b++) wr_reg(DATA0_OFS + 12'(b), word[8*b +: 8]);
        rd_reg(CTRL_TWO_OFS);
        check({31'h0, d[0]}, 32'h1);
        check({25'h0, select_n}, {25'h0, ~(7'h01 << (sel - 3'h1))});
        wait_idle();
        check(32'(nbits), 32'(n));
        f = word >> (32 - n);
        r = reply >> (32 - n);
        check(got, lsb ? rev(f, n) : f);
        exp_w = (word & ~(32'hFFFF_FFFF << (32 - n))) | ((lsb ? rev(r, n) : r) << (32 - n));
        for (int b = 0; b < 4; b++) begin
            rd_reg(DATA0_OFS + 12'(b));
            check({24'h0, d}, {24'h0, exp_w[8*b +: 8]});
        end
        check({25'h0, select_n}, 32'h7F);
        $display("frame test len %0d order %0d rate %0d done", len, lsb, rate);
    endtask : xfer

    initial begin
        void'($urandom(49));
        repeat (4) @(posedge clk);
        reset_n <= 1'b1;
        rd_reg(CTRL_TWO_OFS);
        check({24'h0, d}, 32'h0);
        rd_reg(12'hCAE);
        check({24'h0, d}, 32'h0);
        wr_reg(CTRL_TWO_OFS, 8'hFF);
        rd_reg(CTRL_TWO_OFS);
        check({24'h0, d}, 32'hFC);
        $display("register test done");
        for (int c = 0; c < 5; c++) begin
            wr_reg(CTRL_TWO_OFS, {2'(c), 2'h0, c < 4, 3'h2});
            periph_irq_in_n <= 1'b0;
            repeat (6) @(posedge clk);
            check({28'h0, host_irq}, c < 4 ? 32'h1 << c : 32'h0);
            wr_reg(CTRL_TWO_OFS, {2'(c), 2'h0, c < 4, 3'h0});
            rd_reg(CTRL_TWO_OFS);
            check({31'h0, d[1]}, 32'h1);
            @(posedge clk);
            periph_irq_in_n <= 1'b1;
            repeat (6) @(posedge clk);
            rd_reg(CTRL_TWO_OFS);
            check({27'h0, host_irq, d[1]}, 32'h0);
        end
        $display("interrupt test done");
        for (int k = 0; k < 8; k++) xfer(2'(k / 2), k[0], 2'($urandom_range(3)), 3'($urandom_range(7, 1)));
        xfer(2'h3, 1'b1, 2'h0, 3'h7);
        xfer(2'h0, 1'b0, 2'h3, 3'h1);
        // Four starts back to back: the queue takes two behind the running one
        drops = 0;
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            addr <= DATA3_OFS;
            wdata <= 8'(i);
            wr <= 1'b1;
        end
        @(posedge clk);
        wr <= 1'b0;
        // The refusal pulse stands in the cycle after the fourth start
        repeat (4) begin
            #1 drops += int'(start_dropped);
            @(posedge clk);
        end
        check(32'(drops), 32'h1);
        wait_idle();
        $display("queue test done");
        for (int s = 0; s < 8; s++) begin
            wr_reg(CTRL_ONE_OFS, 8'h08 | 8'(s));
            repeat (3) @(posedge clk);
            check({25'h0, select_n}, s == 0 ? 32'h7F : {25'h0, ~(7'h01 << (s - 1))});
        end
        $display("manual select test done");
        finish_test();
    end
endmodule : spi_master_with_irq_routing_bench

// ===== verification/spi_periph_model.sv
`timescale 1ns/1ps
module spi_periph_model (
    // Serial port
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic [6:0]  select_n,
    output logic             miso,
    // Bench side
    input  wire logic [31:0] reply,
    output logic      [31:0] got,
    output int               nbits
);
    logic sel;
    int   idx = 31;

    assign sel = (select_n != 7'h7F);
    initial miso = 1'b0;
    initial got = 32'h0;
    initial nbits = 0;
    // New frame: first reply bit waits on the line before the first rise
    always @(posedge sel) begin
        idx = 31;
        nbits = 0;
        got = 32'h0;
        miso = reply[31];
    end
    // Capture on rise, next bit on fall
    always @(posedge sclk) if (sel) begin
        got = {got[30:0], mosi};
        nbits++;
    end
    always @(negedge sclk) if (sel && idx > 0) begin
        idx--;
        miso = reply[idx];
    end
    // A released line does not keep its last level
    always @(negedge sel) miso = ~miso;
endmodule : spi_periph_model
